// ### hdl/rms_pkg.sv
// Constants and types for the reset mode strap sampler
package rms_pkg;
    localparam int          RMS_DATA_W          = 16;
    localparam int          RMS_CS_W            = 11;
    localparam int          RMS_ADDR_W          = 24;
    localparam int          RMS_SYNC_W          = 2;
    localparam int          RMS_BIT_PORT_SIZE   = 0;
    localparam int          RMS_BIT_CS_LOW      = 1;
    localparam int          RMS_BIT_CS_MID      = 2;
    localparam int          RMS_BIT_HIADDR_LO   = 3;
    localparam int          RMS_BIT_HIADDR_HI   = 7;
    localparam int          RMS_BIT_STROBE_PORT = 8;
    localparam int          RMS_BIT_IRQ_PORT    = 9;
    localparam int          RMS_BIT_RESERVED    = 11;
    localparam int          RMS_FIRST_CS_ADDR   = 6;
    localparam int          RMS_SYSTEM_CLOCK_OUTPUT_NS       = 50;
    localparam int          RMS_FIRST_CYC_DLY   = 10;
    localparam int          RMS_FIRST_CYC_NS    = RMS_FIRST_CYC_DLY * RMS_SYSTEM_CLOCK_OUTPUT_NS;
    localparam logic [15:0] RMS_STRAP_DEFAULT   = 16'hFFFF;
    localparam logic [23:0] RMS_VECTOR_ADDR     = 24'h000000;
    localparam logic [2:0]  RMS_FC_SUPER_PROG   = 3'h6;

    typedef enum logic [1:0] {
        RMS_ST_RESET = 2'b00,
        RMS_ST_WAIT  = 2'b01,
        RMS_ST_RUN   = 2'b10
    } rms_state_t;
endpackage : rms_pkg

// ### hdl/rms_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module rms_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    // Level
    input  wire logic i_level,
    output logic      o_level
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb begin
        meta_nxt = i_rst ? RESET_VAL : i_level;
        sync_nxt = i_rst ? RESET_VAL : meta_r;
    end

    always_ff @(posedge i_core_clk) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign o_level = sync_r;
endmodule : rms_sync
`default_nettype wire

// ### hdl/rms_sampler.sv
// Reset-time configuration strap sampler
// Operation
// - Undriven data lines read high by default
// - First bus cycle ten clocks after release
// - Boot select active at release, vectors zero
// - Data bit 0 low gives 8-bit boot
// - Bits 1,2 pick chip-select groups function
// - Bits 3-7 low turn selects into addresses
// - Bit 8 low gives strobe pins to port
// - Bit 9 low gives interrupt pins to port
// - Clock strap high selects synthesizer clock
// - Breakpoint low at release enables debug
// - Breakpoint high at release disables debug
// - Relatch each release; hold until reset
// - Breakpoint synchronised; must be low two clocks before release
// - Module pins default to input ports
`timescale 1ns/1ps
`default_nettype none
module rms_sampler
    import rms_pkg::*;
#(
    parameter int DATA_W = rms_pkg::RMS_DATA_W,
    parameter int CS_W   = rms_pkg::RMS_CS_W
) (
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_rst,
    // Strap inputs, captured on the first clock edge that sees reset low; i_internal_breakpoint is not captured, only used live
    input  wire logic [DATA_W-1:0]   i_data_strap,
    input  wire logic [DATA_W-1:0]   i_data_strap_oe_n,
    input  wire logic                i_clock_source_strap,
    input  wire logic                i_breakpoint_request_n,
    input  wire logic                i_internal_breakpoint,
    // Boot and bus start
    output logic                     o_boot_memory_select_n,
    output logic                     o_first_bus_cycle,
    output logic [rms_pkg::RMS_ADDR_W-1:0] o_vector_addr,
    output logic [2:0]               o_vector_fc,
    output logic                     o_boot_port_8bit,
    // Pin assignment
    output logic                     o_cs_low_alt,
    output logic                     o_cs_mid_alt,
    output logic [CS_W-1:0]          o_cs_is_addr,
    output logic                     o_strobe_gpio_port,
    output logic                     o_interrupt_gpio_port,
    output logic                     o_reserved_mode_err,
    // Clock and debug
    output logic                     o_use_synthesizer,
    output logic                     o_background_debug_mode_en,
    output logic                     o_enter_debug,
    output logic                     o_breakpoint_exception,
    // Module ports
    output logic                     o_module_pin_func_en,
    output logic                     o_port_dir_out
);
    import rms_pkg::*;

    function automatic logic [CS_W-1:0] hiaddr_map(input logic [DATA_W-1:0] d);
        logic [CS_W-1:0] m;
        m = '0;
        for (int b = RMS_BIT_HIADDR_LO; b <= RMS_BIT_HIADDR_HI; b++) begin
            if (!d[b]) begin
                for (int c = RMS_FIRST_CS_ADDR; c <= b + RMS_FIRST_CS_ADDR - RMS_BIT_HIADDR_LO; c++) begin
                    m[c] = 1'b1;
                end
            end
        end
        return m;
    endfunction : hiaddr_map

    rms_state_t        state_r;
    rms_state_t        state_nxt;
    logic [3:0]        dly_r;
    logic [3:0]        dly_nxt;
    logic [DATA_W-1:0] strap_r;
    logic [DATA_W-1:0] strap_nxt;
    logic              clk_strap_r;
    logic              clk_strap_nxt;
    logic              bdm_r;
    logic              bdm_nxt;
    logic              first_r;
    logic              first_nxt;
    logic              breakpoint_request_sync_n;
    logic              breakpoint_request_prev_r;
    logic              breakpoint_request_prev_nxt;
    logic [DATA_W-1:0] pins_eff;
    logic              boot_8bit_r;
    logic              boot_8bit_nxt;
    logic              cs_low_r;
    logic              cs_low_nxt;
    logic              cs_mid_r;
    logic              cs_mid_nxt;
    logic [CS_W-1:0]   cs_addr_r;
    logic [CS_W-1:0]   cs_addr_nxt;
    logic              strobe_port_r;
    logic              strobe_port_nxt;
    logic              irq_port_r;
    logic              irq_port_nxt;
    logic              reserved_r;
    logic              reserved_nxt;
    logic              synth_r;
    logic              synth_nxt;

    // Synchroniser adds latency, so a level must be low two clocks before release
    // Never reset, since the pin has to be followed while reset is held
    rms_sync #(.RESET_VAL(1'b1)) u_breakpoint_request_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (1'b0),
        .i_level    (i_breakpoint_request_n),
        .o_level    (breakpoint_request_sync_n)
    );

    // Undriven lines fall to the weak pull-up value
    assign pins_eff = (i_data_strap | i_data_strap_oe_n);

    always_comb begin
        state_nxt     = state_r;
        dly_nxt       = dly_r;
        strap_nxt     = strap_r;
        clk_strap_nxt = clk_strap_r;
        bdm_nxt       = bdm_r;
        first_nxt     = 1'b0;
        breakpoint_request_prev_nxt = breakpoint_request_sync_n;
        unique case (state_r)
            RMS_ST_RESET: begin
                // Capture happens on the release edge only, values then frozen
                strap_nxt     = pins_eff;
                clk_strap_nxt = i_clock_source_strap;
                bdm_nxt       = ~breakpoint_request_sync_n;
                dly_nxt       = 4'h0;
                if (!i_rst) begin
                    state_nxt = RMS_ST_WAIT;
                end
            end
            RMS_ST_WAIT: begin
                dly_nxt = dly_r + 4'h1;
                if (dly_r == 4'(RMS_FIRST_CYC_DLY - 2)) begin
                    first_nxt = 1'b1;
                    state_nxt = RMS_ST_RUN;
                end
            end
            RMS_ST_RUN: begin
                state_nxt = RMS_ST_RUN;
            end
            default: state_nxt = RMS_ST_RESET;
        endcase
        if (i_rst) begin
            state_nxt     = RMS_ST_RESET;
            dly_nxt       = 4'h0;
            strap_nxt     = DATA_W'(RMS_STRAP_DEFAULT);
            clk_strap_nxt = 1'b1;
            bdm_nxt       = 1'b0;
            first_nxt     = 1'b0;
            breakpoint_request_prev_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        state_r     <= state_nxt;
        dly_r       <= dly_nxt;
        strap_r     <= strap_nxt;
        clk_strap_r <= clk_strap_nxt;
        bdm_r       <= bdm_nxt;
        first_r     <= first_nxt;
        breakpoint_request_prev_r <= breakpoint_request_prev_nxt;
    end

    // Decoded map is registered so every configuration output leaves a flop
    always_comb begin
        boot_8bit_nxt   = ~strap_nxt[RMS_BIT_PORT_SIZE];
        cs_low_nxt      = ~strap_nxt[RMS_BIT_CS_LOW];
        cs_mid_nxt      = ~strap_nxt[RMS_BIT_CS_MID];
        cs_addr_nxt     = hiaddr_map(strap_nxt);
        strobe_port_nxt = ~strap_nxt[RMS_BIT_STROBE_PORT];
        irq_port_nxt    = ~strap_nxt[RMS_BIT_IRQ_PORT];
        reserved_nxt    = ~strap_nxt[RMS_BIT_RESERVED];
        synth_nxt       = clk_strap_nxt;
    end

    always_ff @(posedge i_core_clk) begin
        boot_8bit_r   <= boot_8bit_nxt;
        cs_low_r      <= cs_low_nxt;
        cs_mid_r      <= cs_mid_nxt;
        cs_addr_r     <= cs_addr_nxt;
        strobe_port_r <= strobe_port_nxt;
        irq_port_r    <= irq_port_nxt;
        reserved_r    <= reserved_nxt;
        synth_r       <= synth_nxt;
    end

    assign o_boot_memory_select_n = (state_r == RMS_ST_RESET);
    assign o_first_bus_cycle      = first_r;
    assign o_vector_addr          = RMS_VECTOR_ADDR;
    assign o_vector_fc            = RMS_FC_SUPER_PROG;
    assign o_boot_port_8bit       = boot_8bit_r;
    assign o_cs_low_alt           = cs_low_r;
    assign o_cs_mid_alt           = cs_mid_r;
    assign o_cs_is_addr           = cs_addr_r;
    assign o_strobe_gpio_port     = strobe_port_r;
    assign o_interrupt_gpio_port  = irq_port_r;
    assign o_reserved_mode_err    = reserved_r;
    assign o_use_synthesizer      = synth_r;
    assign o_background_debug_mode_en = bdm_r;

    // Falling edge of the synchronised pin or an internal breakpoint
    // Events wait for the first bus cycle so a late strap release is not taken as a request
    logic breakpoint_request_fall;
    logic breakpoint_request_event;
    assign breakpoint_request_fall  = breakpoint_request_prev_r && !breakpoint_request_sync_n;
    assign breakpoint_request_event = (state_r == RMS_ST_RUN) && (breakpoint_request_fall || i_internal_breakpoint);
    assign o_enter_debug          = breakpoint_request_event && bdm_r;
    assign o_breakpoint_exception = breakpoint_request_event && !bdm_r;

    assign o_module_pin_func_en   = 1'b0;
    assign o_port_dir_out         = 1'b0;
endmodule : rms_sampler
`default_nettype wire

// ### tb/rms_strap_model.sv
// Board strap driver and breakpoint source
`timescale 1ns/1ps
`default_nettype none
module rms_strap_model (
    input  wire logic        i_core_clk, i_rst, i_clk_strap, i_breakpoint_request_low,
    input  wire logic [15:0] i_low_mask,
    output logic      [15:0] o_data, o_oe_n,
    output logic             o_clk_strap, o_breakpoint_request_n
);
    int cnt = 0;
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_oe_n      <= ~i_low_mask;
            o_data      <= ~i_low_mask & 16'h5A5A;
            o_clk_strap <= i_clk_strap;
            o_breakpoint_request_n    <= ~i_breakpoint_request_low;
            cnt         <= 0;
        end else begin
            // Released lines wander so a late sample shows up
            o_oe_n      <= 16'hFFFF;
            o_data      <= ~o_data;
            o_clk_strap <= ~o_clk_strap;
            o_breakpoint_request_n    <= !(cnt inside {[14:16]});
            cnt         <= cnt + 1;
        end
    end
endmodule : rms_strap_model
`default_nettype wire

// ### tb/rms_sampler_monitor.sv
// Assertion checker for the strap sampler
`timescale 1ns/1ps
`default_nettype none
module rms_sampler_monitor
    import rms_pkg::*;
#(parameter int DATA_W = 16, parameter int CS_W = 11) (
    input wire logic i_core_clk, i_rst, i_clock_source_strap, i_breakpoint_request_n, i_internal_breakpoint,
    input wire logic [DATA_W-1:0] i_data_strap, i_data_strap_oe_n,
    input wire logic o_boot_memory_select_n, o_first_bus_cycle, o_boot_port_8bit, o_cs_low_alt, o_cs_mid_alt,
    input wire logic [RMS_ADDR_W-1:0] o_vector_addr,
    input wire logic [2:0] o_vector_fc,
    input wire logic [CS_W-1:0] o_cs_is_addr,
    input wire logic o_strobe_gpio_port, o_interrupt_gpio_port, o_reserved_mode_err, o_use_synthesizer,
    input wire logic o_background_debug_mode_en, o_enter_debug, o_breakpoint_exception,
    input wire logic o_module_pin_func_en, o_port_dir_out
);
    logic [DATA_W-1:0] lv;
    logic [CS_W-1:0]   ca;
    always_comb begin
        lv = i_data_strap | i_data_strap_oe_n;
        ca = '0;
        for (int j = 3; j <= 7; j++) if (!lv[j]) for (int n = 6; n <= j + 3; n++) ca[n] = 1'b1;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_rel; $fell(i_rst); endsequence
    sequence s_quiet; !o_first_bus_cycle [*8] ##1 !o_first_bus_cycle [*2]; endsequence
    AST_BOOT_SEL: assert property (s_rel |=> !o_boot_memory_select_n) else $error("boot select idle");
    AST_FIRST_CYC: assert property (s_rel |-> s_quiet ##1 o_first_bus_cycle ##1 !o_first_bus_cycle)
        else $error("first bus cycle misplaced");
    AST_VECTOR: assert property (o_vector_addr == RMS_VECTOR_ADDR && o_vector_fc == RMS_FC_SUPER_PROG)
        else $error("vector fetch wrong");
    AST_BOOT_CFG: assert property (s_rel |=> o_boot_port_8bit == !$past(lv[0]) && o_cs_low_alt == !$past(lv[1])
        && o_cs_mid_alt == !$past(lv[2])) else $error("boot config wrong");
    AST_CS_ADDR: assert property (s_rel |=> o_cs_is_addr == $past(ca)) else $error("address lines wrong");
    AST_PORTS: assert property (s_rel |=> o_strobe_gpio_port == !$past(lv[8])
        && o_interrupt_gpio_port == !$past(lv[9]) && o_reserved_mode_err == !$past(lv[11])) else $error("port map");
    AST_CLOCK: assert property (s_rel |=> o_use_synthesizer == $past(i_clock_source_strap))
        else $error("clock source wrong");
    AST_BDM: assert property (s_rel ##0 ($stable(i_breakpoint_request_n) &&
        $past(i_breakpoint_request_n, 2) == i_breakpoint_request_n) |=>
        o_background_debug_mode_en == !$past(i_breakpoint_request_n)) else $error("debug enable wrong");
    AST_HOLD: assert property (!$past(i_rst) && !$past(i_rst, 2) |-> $stable({o_boot_port_8bit, o_cs_low_alt,
        o_cs_mid_alt, o_cs_is_addr, o_strobe_gpio_port, o_interrupt_gpio_port, o_reserved_mode_err,
        o_use_synthesizer, o_background_debug_mode_en})) else $error("config moved");
    AST_EVENT: assert property ((o_enter_debug |-> o_background_debug_mode_en)
        and (o_breakpoint_exception |-> !o_background_debug_mode_en)) else $error("breakpoint route");
    AST_MOD_PINS: assert property (!o_module_pin_func_en && !o_port_dir_out) else $error("module pins");
endmodule : rms_sampler_monitor
bind rms_sampler rms_sampler_monitor #(.DATA_W(DATA_W), .CS_W(CS_W)) u_mon (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_clock_source_strap(i_clock_source_strap),
    .i_breakpoint_request_n(i_breakpoint_request_n), .i_internal_breakpoint(i_internal_breakpoint),
    .i_data_strap(i_data_strap), .i_data_strap_oe_n(i_data_strap_oe_n),
    .o_boot_memory_select_n(o_boot_memory_select_n), .o_first_bus_cycle(o_first_bus_cycle),
    .o_boot_port_8bit(o_boot_port_8bit), .o_cs_low_alt(o_cs_low_alt), .o_cs_mid_alt(o_cs_mid_alt),
    .o_vector_addr(o_vector_addr), .o_vector_fc(o_vector_fc), .o_cs_is_addr(o_cs_is_addr),
    .o_strobe_gpio_port(o_strobe_gpio_port), .o_interrupt_gpio_port(o_interrupt_gpio_port),
    .o_reserved_mode_err(o_reserved_mode_err), .o_use_synthesizer(o_use_synthesizer),
    .o_background_debug_mode_en(o_background_debug_mode_en), .o_enter_debug(o_enter_debug),
    .o_breakpoint_exception(o_breakpoint_exception), .o_module_pin_func_en(o_module_pin_func_en),
    .o_port_dir_out(o_port_dir_out));
`default_nettype wire

// ### tb/reset_mode_strap_sampler_bench.sv
// Self-checking bench for the strap sampler
`timescale 1ns/1ps
`default_nettype none
module reset_mode_strap_sampler_bench;
    import rms_pkg::*;
    logic i_core_clk = 1'b0, i_rst = 1'b1, ibk = 1'b0, cks = 1'b1, bkl = 1'b0;
    logic [15:0] msk = 16'h0000;
    wire logic [15:0] dat, oen;
    wire logic ckp, bkn;
    logic bsn, fbc, p8, cl, cm, sp, ip, re, us, background_debug_mode, ed, bx, mf, pd;
    logic [23:0] va;
    logic [2:0] vf;
    logic [10:0] ca;
    logic [18:0] ex;
    int fails = 0, checks_done = 0, seed = 97453, cyc = 0, k, fc, nd, ne;
    rms_strap_model u_brd (.i_core_clk, .i_rst, .i_clk_strap(cks), .i_breakpoint_request_low(bkl), .i_low_mask(msk),
        .o_data(dat), .o_oe_n(oen), .o_clk_strap(ckp), .o_breakpoint_request_n(bkn));
    rms_sampler dut (.i_core_clk, .i_rst, .i_data_strap(dat), .i_data_strap_oe_n(oen), .i_clock_source_strap(ckp),
        .i_breakpoint_request_n(bkn), .i_internal_breakpoint(ibk), .o_boot_memory_select_n(bsn),
        .o_first_bus_cycle(fbc), .o_vector_addr(va), .o_vector_fc(vf), .o_boot_port_8bit(p8), .o_cs_low_alt(cl),
        .o_cs_mid_alt(cm), .o_cs_is_addr(ca), .o_strobe_gpio_port(sp), .o_interrupt_gpio_port(ip),
        .o_reserved_mode_err(re), .o_use_synthesizer(us), .o_background_debug_mode_en(background_debug_mode), .o_enter_debug(ed),
        .o_breakpoint_exception(bx), .o_module_pin_func_en(mf), .o_port_dir_out(pd));
    initial forever #25 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin fails++; $display("BAD t=%0t got %h want %h", $time, g, e); end
    endtask : chk
    task automatic conclude();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    function automatic logic [18:0] cfg();
        return {p8, cl, cm, ca, sp, ip, re, us, background_debug_mode};
    endfunction : cfg
    initial begin
        for (int r = 0; r < 6; r++) begin
            @(posedge i_core_clk);
            // Bit 11 stays undriven except in the one run that probes the reserved setting
            msk <= (r == 1) ? 16'h0800 : 16'($random(seed)) & 16'hF7FF;
            cks <= 1'($random(seed));
            bkl <= 1'($random(seed));
            i_rst <= 1'b1;
            repeat (4) @(posedge i_core_clk);
            #1 chk({bsn, cfg()}, 20'h80002);
            ex = {msk[0], msk[1], msk[2], 11'h000, msk[8], msk[9], msk[11], cks, bkl};
            for (int j = 3; j <= 7; j++) if (msk[j]) for (int n = 6; n <= j + 3; n++) ex[5 + n] = 1'b1;
            @(posedge i_core_clk);
            i_rst <= 1'b0;
            {fc, nd, ne} = '0;
            for (k = 0; k <= 40; k++) begin
                @(posedge i_core_clk);
                ibk <= (k == 3 || k == 30);
                #1;
                if (fbc === 1'b1) fc = k + (fc != 0) * 100;
                nd += (ed === 1'b1);
                ne += (bx === 1'b1);
                if (k == 1 || k == 40) chk(cfg(), ex);
            end
            chk(fc, 9);
            chk(bsn, 0);
            chk({va, vf, mf, pd}, {RMS_VECTOR_ADDR, RMS_FC_SUPER_PROG, 2'b00});
            chk(bkl ? nd : ne, 2);
            chk(bkl ? ne : nd, 0);
            $display("run %0d done", r);
        end
        conclude();
    end
endmodule : reset_mode_strap_sampler_bench
`default_nettype wire
